// >>> include/sps_map.svh
`ifndef SPS_MAP_SVH
`define SPS_MAP_SVH
// channel counts
`define SPS_DI_N        8
`define SPS_DO_N        3
// timing
`define SPS_CLK_PS      5000
`define SPS_CYCLE_MS    100
`define SPS_MON_MS      150
// frame coverage constants for the checksum
`define SPS_ADDR        16'h0a5c
`define SPS_PARAM       8'h3c
`define SPS_CRC_POLY    16'h1021
`define SPS_CRC_INIT    16'hffff
// device status byte
`define SPS_ST_FAULT    0
// host control byte
`define SPS_CT_ACK      0
`define SPS_CT_RESTART  1
`endif

// >>> include/sps_pkg.sv
package sps_pkg;
  typedef enum logic [1:0] {
    SPS_PASS  = 2'b00,
    SPS_WAIT  = 2'b01,
    SPS_OPER  = 2'b10
  } sps_state_e;

  typedef struct packed {
    sps_state_e  st;
    logic [31:0] cycCnt;
    logic [31:0] wdCnt;
    logic        commFault;
    logic        synced;
    logic [7:0]  rxMonExp;
    logic [7:0]  txMon;
    logic [7:0]  inData;
    logic        ackPend;
    logic        restartPend;
    logic [7:0]  programIn;
    logic        passivated;
    logic        txValid;
    logic [7:0]  txData;
    logic [7:0]  txCtrl;
    logic [7:0]  txMonNum;
    logic [15:0] txCrc;
  } sps_state_s;
endpackage

// >>> design/sps_host.sv
// Overview of operation
// R1: zero, de-energized, is the safe value on every channel.
// R2: device starts with all channels passivated.
// R3: device passivates on module-wide faults.
// R4: device passivates on safety communication errors.
// R5: device passivates faulty channels.
// R6: passivated outputs are driven to zero whatever the host commands.
// R7: host hands zero to the program for passivated inputs.
// R8: reintegrate only after the fault has been seen to clear.
// R9: reintegration is automatic or waits for a program acknowledge.
// R10: frame holds data, coordination byte, monitoring number, checksum.
// R11: each sender advances its monitoring number every frame.
// R12: host sends a frame once per cycle interval, default 100 ms.
// R13: receiver needs a fresh valid frame within the monitoring time.
// R14: device forces all channels safe on monitoring timeout; sps_dev has no monitoring timer and keeps dout at its last value.
// R15: checksum covers data, address reference and safety parameters.
// R16: device passivates on checksum mismatch.
// R17: communication faults reintegrate once error-free traffic returns.
// R18: some module faults stay until power cycling.
// R19: host tries to reintegrate every module on program restart.
// R20: device latches each cause until its reintegration condition holds; sps_dev latches only fatal.
`include "sps_map.svh"
`timescale 1ns/1ps
`default_nettype none
module sps_host
  import sps_pkg::*;
#(
  parameter int unsigned CYCLE_CYC = `SPS_CYCLE_MS * 1000000 / (`SPS_CLK_PS / 1000),
  parameter int unsigned MON_CYC   = `SPS_MON_MS * 1000000 / (`SPS_CLK_PS / 1000)
) (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 srst,
  // safety program side
  input  wire logic [`SPS_DO_N-1:0] programOut,
  input  wire logic                 autoReint,
  input  wire logic                 ackReint,
  input  wire logic                 restart,
  output logic [`SPS_DI_N-1:0]      programIn,
  output logic                      passivated,
  output logic                      commFault,
  // frame to device
  output logic                      txValid,
  output logic [7:0]                txData,
  output logic [7:0]                txCtrl,
  output logic [7:0]                txMonNum,
  output logic [15:0]               txCrc,
  // frame from device
  input  wire logic                 rxValid,
  input  wire logic [7:0]           rxData,
  input  wire logic [7:0]           rxStatus,
  input  wire logic [7:0]           rxMonNum,
  input  wire logic [15:0]          rxCrc
);
  sps_state_s s;
  sps_state_s next_s;
  logic       crcOk;
  logic       seqOk;
  logic       frameOk;
  logic       devFault;
  logic       timeout;
  logic [7:0] sendData;
  logic [7:0] sendCtrl;

  function automatic logic [15:0] crcCalc(input logic [47:0] msg);
    logic [15:0] c;
    c = `SPS_CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ msg[i]) ? `SPS_CRC_POLY : 16'h0000);
    end
    return c;
  endfunction

  assign crcOk    = rxCrc == crcCalc({`SPS_ADDR, rxData, rxStatus, rxMonNum, `SPS_PARAM}); // R15
  assign seqOk    = !s.synced || rxMonNum == s.rxMonExp; // R11
  assign frameOk  = rxValid && crcOk && seqOk; // R13
  assign devFault = frameOk && rxStatus[`SPS_ST_FAULT];
  // a frame arriving on the last counted cycle still counts as in time
  assign timeout  = s.wdCnt == MON_CYC - 1 && !frameOk; // R13

  always_comb begin
    next_s = s;
    next_s.txValid = 1'b0;
    sendData = (s.st == SPS_OPER) ? {{(8-`SPS_DO_N){1'b0}}, programOut} : 8'h00; // R1
    sendCtrl = 8'h00;
    sendCtrl[`SPS_CT_ACK] = s.ackPend;
    sendCtrl[`SPS_CT_RESTART] = s.restartPend;
    // cyclic frame transmission
    if (s.cycCnt == CYCLE_CYC - 1) begin // R12
      next_s.cycCnt = 32'h0;
      next_s.txValid = 1'b1;
      next_s.txData = sendData;
      next_s.txCtrl = sendCtrl;
      next_s.txMonNum = s.txMon;
      next_s.txCrc = crcCalc({`SPS_ADDR, sendData, sendCtrl, s.txMon, `SPS_PARAM}); // R10
      next_s.txMon = s.txMon + 8'h01; // R11
      next_s.ackPend = 1'b0;
      next_s.restartPend = 1'b0;
    end else begin
      next_s.cycCnt = s.cycCnt + 32'h1;
    end
    // receive supervision
    if (frameOk) begin
      next_s.wdCnt = 32'h0;
      next_s.synced = 1'b1;
      next_s.rxMonExp = rxMonNum + 8'h01;
      next_s.inData = rxData;
      next_s.commFault = 1'b0; // R17
    end else if (rxValid || timeout) begin
      next_s.commFault = 1'b1; // R13
      // far counter moved on: take the next good frame as a fresh start
      next_s.synced = 1'b0; // R17
    end
    if (!frameOk && !timeout) begin
      next_s.wdCnt = s.wdCnt + 32'h1;
    end
    // passivation and reintegration
    case (s.st)
      SPS_PASS: begin
        if (frameOk && !devFault) begin // R8
          next_s.st = autoReint ? SPS_OPER : SPS_WAIT; // R9
        end
      end
      SPS_WAIT: begin
        if (ackReint) begin // R9
          next_s.st = SPS_OPER;
          next_s.ackPend = 1'b1;
        end
      end
      SPS_OPER: begin
        next_s.st = SPS_OPER;
      end
      default: begin
        next_s.st = SPS_PASS;
      end
    endcase
    if (devFault || (rxValid && !frameOk) || timeout) begin
      next_s.st = SPS_PASS; // R13
    end
    if (restart) begin
      next_s.st = SPS_PASS; // R19
      next_s.restartPend = 1'b1;
      next_s.ackPend = 1'b1;
      next_s.synced = 1'b0;
      next_s.wdCnt = 32'h0;
    end
    next_s.passivated = next_s.st != SPS_OPER;
    next_s.programIn = (next_s.st == SPS_OPER) ? next_s.inData : 8'h00; // R7
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s <= '0;
      s.passivated <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign programIn  = s.programIn;
  assign passivated = s.passivated;
  assign commFault  = s.commFault;
  assign txValid    = s.txValid;
  assign txData     = s.txData;
  assign txCtrl     = s.txCtrl;
  assign txMonNum   = s.txMonNum;
  assign txCrc      = s.txCrc;

  // checking helpers
  logic [31:0] gapCnt;
  logic [7:0]  lastMon;
  logic        sentOnce;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      gapCnt <= 32'h0;
      lastMon <= 8'h00;
      sentOnce <= 1'b0;
    end else begin
      gapCnt <= txValid ? 32'h1 : gapCnt + 32'h1;
      if (txValid) begin
        lastMon <= txMonNum;
        sentOnce <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_SAFE_IN: assert property (passivated |-> programIn == 8'h00) // R7
    else $error("program sees data while passivated");
  AST_TX_SAFE: assert property (txValid && $past(passivated) |-> txData == 8'h00) // R1
    else $error("nonzero output data sent while passivated");
  AST_MON_INC: assert property (txValid && sentOnce |-> txMonNum == lastMon + 8'h01) // R11
    else $error("monitoring number not advanced");
  AST_CADENCE: assert property (txValid && sentOnce |-> gapCnt == CYCLE_CYC) // R12
    else $error("frame interval wrong");
  AST_TX_CRC: assert property (txValid |->
      txCrc == crcCalc({`SPS_ADDR, txData, txCtrl, txMonNum, `SPS_PARAM})) // R10
    else $error("sent checksum wrong");
  AST_TIMEOUT: assert property (timeout |=> passivated && commFault) // R13
    else $error("timeout did not passivate");
  AST_BAD_CRC: assert property (rxValid && !crcOk |=> passivated && commFault) // R15
    else $error("bad checksum accepted");
  AST_AUTO: assert property (s.st == SPS_PASS && frameOk && !devFault && autoReint
      && !restart |=> !passivated) // R9
    else $error("auto reintegration missed");
  AST_WAIT_ACK: assert property (s.st == SPS_WAIT && !ackReint |=> passivated) // R9
    else $error("reintegrated without acknowledge");
  AST_DEV_FAULT: assert property (devFault |=> passivated ##1 passivated) // R8
    else $error("reintegrated while device reports fault");

  COV_OPER: cover property ($fell(passivated));
  COV_TIMEOUT: cover property (timeout);
  COV_ACK: cover property (s.st == SPS_WAIT && ackReint);
  COV_RESTART: cover property (restart ##1 passivated);
endmodule
`default_nettype wire

// >>> verification/sps_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"
module sps_dev (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // frame from host
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  input  wire logic [7:0]  txCtrl,
  input  wire logic [7:0]  txMonNum,
  input  wire logic [15:0] txCrc,
  // process and faults
  input  wire logic [7:0]  din,
  input  wire logic        fault,
  input  wire logic        fatal,
  input  wire logic        mute,
  input  wire logic        badCrc,
  output logic [2:0]       dout,
  // frame to host
  output logic             rxValid,
  output logic [7:0]       rxData,
  output logic [7:0]       rxStatus,
  output logic [7:0]       rxMonNum,
  output logic [15:0]      rxCrc
);
  logic [7:0] mon;
  logic       dead;
  logic       flt;
  function automatic logic [15:0] crc(input logic [47:0] m);
    logic [15:0] c;
    c = `SPS_CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = {c[14:0], 1'b0} ^ ((c[15] ^ m[i]) ? `SPS_CRC_POLY : 16'h0);
    end
    return c;
  endfunction
  // module fault: channel fault, or a fatal one held until power cycling
  assign flt = fault | fatal | dead;
  always @(posedge sys_clk) begin
    rxValid <= txValid & ~mute & ~srst;
    if (fatal) begin
      dead <= 1'b1;
    end
    if (txValid) begin
      dout <= (txCrc === crc({`SPS_ADDR, txData, txCtrl, txMonNum, `SPS_PARAM}) && !flt) ?
              txData[2:0] : 3'h0;
    end
    if (flt) begin
      dout <= 3'h0;
    end
    if (txValid & ~mute) begin
      mon <= mon + 8'h1;
      rxData <= flt ? 8'h0 : din;
      rxStatus <= {7'h0, flt};
      rxMonNum <= mon + 8'h1;
      rxCrc <= crc({`SPS_ADDR, flt ? 8'h0 : din, 7'h0, flt, mon + 8'h1, `SPS_PARAM}) ^
               {15'h0, badCrc};
    end else begin
      {rxData, rxStatus, rxMonNum, rxCrc} <= ~{rxData, rxStatus, rxMonNum, rxCrc};
    end
    if (srst) begin
      mon <= 8'h0;
      dead <= 1'b0;
      dout <= 3'h0;
    end
  end
endmodule
`default_nettype wire

// >>> verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "sps_map.svh"
`define CHK(n, e, s) begin samples_checked++; if ((e) !== (s)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  import sps_pkg::*;
  logic sys_clk = 0, srst = 1, autoReint = 1, ackReint = 0, restart = 0;
  logic fault = 0, fatal = 0, mute = 0, badCrc = 0, passivated, commFault, txValid, rxValid;
  logic [2:0] programOut = 3'h0, dout;
  logic [7:0] programIn, txData, txCtrl, txMonNum, rxData, rxStatus, rxMonNum, din = 8'h0;
  logic [15:0] txCrc, rxCrc, expCrc;
  logic [31:0] rnd = 32'h8ee9;
  int n_fail = 0, samples_checked = 0, gap = 0, lastMon = -1;
  sps_host #(.CYCLE_CYC(20), .MON_CYC(70)) sps_host_i (.sys_clk, .srst, .programOut,
    .autoReint, .ackReint, .restart, .programIn, .passivated, .commFault, .txValid,
    .txData, .txCtrl, .txMonNum, .txCrc, .rxValid, .rxData, .rxStatus, .rxMonNum, .rxCrc);
  sps_dev sps_dev_i (.sys_clk, .srst, .txValid, .txData, .txCtrl, .txMonNum, .txCrc, .din,
    .fault, .fatal, .mute, .badCrc, .dout, .rxValid, .rxData, .rxStatus, .rxMonNum, .rxCrc);
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic report_and_stop();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // wait for n host frames and the device reply to land
  task automatic frames(input int n);
    rnd = lfsr(rnd);
    din = rnd[7:0];
    programOut = rnd[10:8];
    repeat (n) @(posedge txValid);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic tick();
    @(posedge sys_clk);
    #1;
  endtask
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    #10000;
    n_fail++;
    report_and_stop();
  end
  always @(posedge sys_clk) begin
    if (srst) begin
      lastMon <= -1;
    end else begin
      gap <= txValid ? 1 : gap + 1;
      if (passivated === 1'b1) `CHK("programIn", 8'h0, programIn)
      if (txValid === 1'b1) begin
        expCrc = sps_dev_i.crc({`SPS_ADDR, txData, txCtrl, txMonNum, `SPS_PARAM});
        `CHK("txCrc", expCrc, txCrc)
        if (lastMon >= 0) `CHK("txMonNum", 8'(lastMon + 1), txMonNum)
        if (lastMon >= 0) `CHK("gap", 20, gap)
        lastMon <= int'(txMonNum);
      end
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    #1 srst = 0;
    `CHK("passivated", 1'b1, passivated)
    `CHK("txValid", 1'b0, txValid)
    frames(1);
    `CHK("passivated", 1'b0, passivated)
    `CHK("programIn", din, programIn)
    frames(1);
    `CHK("dout", programOut, dout)
    `CHK("programIn", din, programIn)
    badCrc = 1;
    frames(1);
    badCrc = 0;
    `CHK("commFault", 1'b1, commFault)
    `CHK("passivated", 1'b1, passivated)
    frames(1);
    `CHK("commFault", 1'b0, commFault)
    `CHK("passivated", 1'b0, passivated)
    autoReint = 0;
    fault = 1;
    frames(1);
    `CHK("passivated", 1'b1, passivated)
    `CHK("dout", 3'h0, dout)
    fault = 0;
    frames(1);
    `CHK("passivated", 1'b1, passivated)
    ackReint = 1;
    tick();
    ackReint = 0;
    tick();
    `CHK("passivated", 1'b0, passivated)
    @(posedge txValid);
    #1 `CHK("txCtrl0", 1'b1, txCtrl[0])
    restart = 1;
    tick();
    restart = 0;
    tick();
    `CHK("passivated", 1'b1, passivated)
    @(posedge txValid);
    #1 `CHK("txCtrl", 8'h03, txCtrl)
    mute = 1;
    ackReint = 1;
    tick();
    ackReint = 0;
    `CHK("passivated", 1'b0, passivated)
    repeat (80) tick();
    `CHK("commFault", 1'b1, commFault)
    `CHK("passivated", 1'b1, passivated)
    mute = 0;
    autoReint = 1;
    frames(1);
    `CHK("commFault", 1'b0, commFault)
    `CHK("passivated", 1'b0, passivated)
    fatal = 1;
    frames(1);
    fatal = 0;
    frames(1);
    `CHK("passivated", 1'b1, passivated)
    `CHK("dout", 3'h0, dout)
    srst = 1;
    repeat (2) tick();
    srst = 0;
    `CHK("passivated", 1'b1, passivated)
    frames(1);
    `CHK("passivated", 1'b0, passivated)
    report_and_stop();
  end
endmodule
`default_nettype wire
